// ===== hw/svwd_pkg.sv
/*
 Shared constants, types and state encodings of the supervisor reset and watchdog logic.
 Assumes a 200 MHz mclk, a synchronous active-high rst and asynchronous pin inputs.
*/
// Summary of operation
// R1 - undervoltage or manual reset drives reset low
// R2 - reset held 200ms after all causes clear
// R3 - watchdog periods: initial 102.4s, normal 1.6s
// R4 - initial period starts whenever fault output rises
// R5 - after initial period, kick falling edge restarts
// R6 - no kick within normal period drives fault low
// R7 - fault stays low until next kick transition
// R8 - fault pulse lasts about 5us for reset
// R9 - reset assertion clears timer, fault returns high
// R10 - timer held cleared while reset is low
// R11 - watchdog-caused reset also lasts full delay
// R12 - host kicks at least once per 1.6s
// R13 - margin hold low freezes all three outputs
// R14 - margin hold overrides manual reset
// R15 - manual reset held low at least 1us
// R16 - timeouts counted from free-running internal timebase
package svwd_pkg;

   // clock and timebase
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 8;
   localparam logic [TICK_W-1:0] TICK_LIM = TICK_W'(TICK_CYC - 1);

   // times as printed, then counts of timebase ticks
   localparam int RST_DELAY_MS = 200;
   localparam int INIT_WD_DECISEC = 1024;
   localparam int NORM_WD_DECISEC = 16;
   localparam int OV_DELAY_US = 25;
   localparam int PWRUP_DELAY_US = 1000;
   localparam int RST_DELAY_TICKS = RST_DELAY_MS * (1000000 / TICK_PERIOD_NS);
   localparam int INIT_WD_TICKS = INIT_WD_DECISEC * (100000000 / TICK_PERIOD_NS);
   localparam int NORM_WD_TICKS = NORM_WD_DECISEC * (100000000 / TICK_PERIOD_NS);
   localparam int OV_DELAY_TICKS = OV_DELAY_US * (1000 / TICK_PERIOD_NS);
   localparam int PWRUP_TICKS = PWRUP_DELAY_US * (1000 / TICK_PERIOD_NS);
   localparam int TCNT_W = 27;

   // short counts in mclk cycles (least times, rounded up)
   localparam int FAULT_PULSE_NS = 5000;
   localparam int FAULT_MIN_CYC = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W = 10;
   localparam logic [HOLD_W-1:0] HOLD_LIM = HOLD_W'(FAULT_MIN_CYC - 1);
   localparam int MR_GLITCH_NS = 100;
   localparam int MR_FILT_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MR_W = 5;
   localparam logic [MR_W-1:0] MR_LIM = MR_W'(MR_FILT_CYC);

   localparam int NUM_SUP = 6;

   typedef struct packed {
      logic [NUM_SUP-1:0] uv;
      logic [NUM_SUP-1:0] ov;
      logic mr_n;
      logic margin_n;
      logic kick;
   } svwd_pins_t;

   // values after reset
   localparam svwd_pins_t PINS_RST = '{uv: 6'h3F, ov: 6'h00, mr_n: 1'h1, margin_n: 1'h1,
                                       kick: 1'h0};
   localparam logic RESET_N_RST = 1'h0;
   localparam logic WD_FAULT_N_RST = 1'h0;
   localparam logic OV_N_RST = 1'h0;

   typedef enum logic [1:0] {
      RS_ACTIVE = 2'h0,
      RS_DELAY = 2'h1,
      RS_RUN = 2'h3
   } svwd_rs_t;

   typedef enum logic [2:0] {
      WD_PWRUP = 3'h0,
      WD_CLEAR = 3'h1,
      WD_INIT = 3'h3,
      WD_NORM = 3'h2,
      WD_FAULT = 3'h6
   } svwd_wd_t;

endpackage : svwd_pkg

// ===== hw/svwd_front.sv
/*
 Pin synchroniser and free-running 1us timebase.
 Assumes every pin input is asynchronous to mclk.
*/
`timescale 1ns/1ps
module svwd_front import svwd_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // raw pins and their synchronised copy
   input wire svwd_pins_t pins_in,
   output svwd_pins_t pins_s,
   // one-cycle timebase strobe
   output logic tick
);

   svwd_pins_t meta;
   logic [TICK_W-1:0] tcnt;
   logic [TICK_W-1:0] next_tcnt;
   logic next_tick;

   // meta is read only by the second stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta <= PINS_RST;
         pins_s <= PINS_RST;
      end else begin
         meta <= pins_in;
         pins_s <= meta;
      end
   end

   always_comb begin
      next_tick = (tcnt == TICK_LIM); // [R16]
      next_tcnt = next_tick ? '0 : tcnt + TICK_W'(1);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tcnt <= '0;
         tick <= 1'h0;
      end else begin
         tcnt <= next_tcnt;
         tick <= next_tick;
      end
   end

   a_tick_period: assert property ( // [R16]
      @(posedge mclk) disable iff (rst) tick |-> ##200 tick)
      else $error("timebase strobe period wrong");

   a_tick_single: assert property ( // [R16]
      @(posedge mclk) disable iff (rst) tick |=> !tick [*8])
      else $error("timebase strobe too wide");

endmodule : svwd_front

// ===== hw/svwd_top.sv
/*
 Reset sequencer, overvoltage stretcher and watchdog of a multi-supply supervisor.
 Assumes comparator results arrive as asynchronous active-high flags, that all
 open-drain outputs are pulled up outside, and that the wired fault-to-manual-reset
 loop, if used, is closed outside this block.
*/
`timescale 1ns/1ps
module svwd_top import svwd_pkg::*; #(
   parameter int unsigned RST_DELAY_T = RST_DELAY_TICKS,
   parameter int unsigned INIT_WD_T = INIT_WD_TICKS,
   parameter int unsigned NORM_WD_T = NORM_WD_TICKS,
   parameter int unsigned OV_DELAY_T = OV_DELAY_TICKS,
   parameter int unsigned PWRUP_T = PWRUP_TICKS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // supply comparator flags, high while out of range
   input wire logic [NUM_SUP-1:0] uv_flag,
   input wire logic [NUM_SUP-1:0] ov_flag,
   // control pins
   input wire logic manual_rst_n,
   input wire logic margin_hold_n,
   input wire logic wd_kick_in,
   // open-drain outputs: pin pulled low while oe is high
   output logic reset_n_o,
   output logic reset_n_oe,
   output logic over_volt_n_o,
   output logic over_volt_n_oe,
   output logic wd_fault_n_o,
   output logic wd_fault_n_oe
);

   // one spare tick: the first tick may come at once, so the delay is never short
   localparam logic [TCNT_W-1:0] RST_LIM = TCNT_W'(RST_DELAY_T);
   localparam logic [TCNT_W-1:0] RST_FULL = TCNT_W'(RST_DELAY_T);
   localparam logic [TCNT_W-1:0] INIT_LIM = TCNT_W'(INIT_WD_T - 1);
   localparam logic [TCNT_W-1:0] NORM_LIM = TCNT_W'(NORM_WD_T - 1);
   localparam logic [TCNT_W-1:0] OV_LIM = TCNT_W'(OV_DELAY_T - 1);
   localparam logic [TCNT_W-1:0] PWRUP_LIM = TCNT_W'(PWRUP_T - 1);

   // true on the tick that ends a count of lim+1 ticks
   function automatic logic expired(input logic stb, input logic [TCNT_W-1:0] cnt,
                                    input logic [TCNT_W-1:0] lim);
      return stb && (cnt == lim);
   endfunction : expired

   svwd_pins_t pins_in;
   svwd_pins_t ps;
   logic tick;
   logic freeze;
   logic kick_prev;
   logic kick_edge;
   logic kick_fall;

   logic [MR_W-1:0] mr_cnt;
   logic [MR_W-1:0] next_mr_cnt;
   logic mr_active;
   logic rst_cause;

   svwd_rs_t rs_state;
   svwd_rs_t next_rs;
   logic [TCNT_W-1:0] rcnt;
   logic [TCNT_W-1:0] next_rcnt;
   logic reset_n;
   logic next_reset_n;

   svwd_wd_t wd_state;
   svwd_wd_t next_wd;
   logic [TCNT_W-1:0] wcnt;
   logic [TCNT_W-1:0] next_wcnt;
   logic [HOLD_W-1:0] hold_cnt;
   logic [HOLD_W-1:0] next_hold_cnt;
   logic wd_fault_n;
   logic next_wd_fault_n;

   logic [TCNT_W-1:0] ocnt;
   logic [TCNT_W-1:0] next_ocnt;
   logic over_volt_n;
   logic next_over_volt_n;

   logic [TCNT_W-1:0] clr_ticks;

   assign pins_in = '{uv: uv_flag, ov: ov_flag, mr_n: manual_rst_n,
                      margin_n: margin_hold_n, kick: wd_kick_in};

   svwd_front u_front (
      .mclk(mclk),
      .rst(rst),
      .pins_in(pins_in),
      .pins_s(ps),
      .tick(tick)
   );

   // margin hold stalls every state machine, so outputs cannot move
   assign freeze = !ps.margin_n; // [R13] [R14]
   assign kick_edge = ps.kick ^ kick_prev;
   assign kick_fall = kick_prev & !ps.kick;

   // manual reset filter: short falling glitches never reach the sequencer
   always_comb begin
      next_mr_cnt = mr_cnt;
      if (ps.mr_n) begin
         next_mr_cnt = '0;
      end else if (mr_cnt != MR_LIM) begin
         next_mr_cnt = mr_cnt + MR_W'(1);
      end
   end

   assign mr_active = (mr_cnt == MR_LIM); // [R15]
   assign rst_cause = (|ps.uv) | mr_active; // [R1]

   always_ff @(posedge mclk) begin
      if (rst) begin
         mr_cnt <= '0;
         kick_prev <= PINS_RST.kick;
      end else begin
         mr_cnt <= next_mr_cnt;
         kick_prev <= ps.kick;
      end
   end

   // reset sequencer
   always_comb begin
      next_rs = rs_state;
      next_rcnt = rcnt;
      if (!freeze) begin // [R14]
         if (rst_cause) begin
            next_rs = RS_ACTIVE; // [R1]
            next_rcnt = '0;
         end else begin
            unique case (rs_state)
               RS_ACTIVE: begin
                  next_rs = RS_DELAY;
                  next_rcnt = '0;
               end
               RS_DELAY: begin
                  // any cause, a watchdog one too, restarts the full delay
                  if (expired(tick, rcnt, RST_LIM)) begin // [R2] [R11]
                     next_rs = RS_RUN;
                  end else if (tick) begin
                     next_rcnt = rcnt + TCNT_W'(1);
                  end
               end
               RS_RUN: begin
                  next_rs = RS_RUN;
               end
               default: begin
                  next_rs = RS_ACTIVE;
                  next_rcnt = '0;
               end
            endcase
         end
      end
      next_reset_n = (next_rs == RS_RUN);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rs_state <= RS_ACTIVE;
         rcnt <= '0;
         reset_n <= RESET_N_RST;
      end else begin
         rs_state <= next_rs;
         rcnt <= next_rcnt;
         reset_n <= next_reset_n;
      end
   end

   // watchdog; one counter serves power-up, initial and normal periods
   always_comb begin
      next_wd = wd_state;
      next_wcnt = wcnt;
      next_hold_cnt = hold_cnt;
      next_wd_fault_n = wd_fault_n;
      if (!freeze) begin // [R13]
         unique case (wd_state)
            WD_PWRUP: begin
               next_wd_fault_n = 1'h0;
               if (expired(tick, wcnt, PWRUP_LIM)) begin // [R16]
                  next_wd_fault_n = 1'h1;
                  next_wcnt = '0;
                  next_wd = reset_n ? WD_INIT : WD_CLEAR; // [R4]
               end else if (tick) begin
                  next_wcnt = wcnt + TCNT_W'(1);
               end
            end
            WD_CLEAR: begin
               next_wd_fault_n = 1'h1;
               next_wcnt = '0; // [R10]
               if (reset_n) begin
                  next_wd = WD_INIT; // [R4]
               end
            end
            WD_INIT: begin
               // kicks are ignored until the long initial period has run out
               if (!reset_n) begin
                  next_wd = WD_CLEAR; // [R9]
                  next_wcnt = '0;
               end else if (expired(tick, wcnt, INIT_LIM)) begin // [R3]
                  next_wd = WD_NORM;
                  next_wcnt = '0;
               end else if (tick) begin
                  next_wcnt = wcnt + TCNT_W'(1);
               end
            end
            WD_NORM: begin
               if (!reset_n) begin
                  next_wd = WD_CLEAR; // [R9]
                  next_wcnt = '0;
               end else if (kick_fall) begin
                  next_wcnt = '0; // [R5]
               end else if (expired(tick, wcnt, NORM_LIM)) begin // [R3] [R6]
                  next_wd = WD_FAULT;
                  next_wd_fault_n = 1'h0;
                  next_hold_cnt = '0;
               end else if (tick) begin
                  next_wcnt = wcnt + TCNT_W'(1);
               end
            end
            WD_FAULT: begin
               next_wd_fault_n = 1'h0; // [R7]
               if (hold_cnt != HOLD_LIM) begin
                  next_hold_cnt = hold_cnt + HOLD_W'(1);
               end
               // a reset ends the fault only after the minimum pulse width
               if (!reset_n && hold_cnt == HOLD_LIM) begin // [R8] [R9]
                  next_wd = WD_CLEAR;
                  next_wd_fault_n = 1'h1;
                  next_wcnt = '0;
               end else if (kick_edge && reset_n) begin // [R7] [R4]
                  next_wd = WD_INIT;
                  next_wd_fault_n = 1'h1;
                  next_wcnt = '0;
               end
            end
            default: begin
               next_wd = WD_PWRUP;
               next_wcnt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wd_state <= WD_PWRUP;
         wcnt <= '0;
         hold_cnt <= '0;
         wd_fault_n <= WD_FAULT_N_RST;
      end else begin
         wd_state <= next_wd;
         wcnt <= next_wcnt;
         hold_cnt <= next_hold_cnt;
         wd_fault_n <= next_wd_fault_n;
      end
   end

   // overvoltage output, stretched after the last input falls back
   always_comb begin
      next_ocnt = ocnt;
      next_over_volt_n = over_volt_n;
      if (!freeze) begin // [R13]
         if (|ps.ov) begin
            next_ocnt = '0;
            next_over_volt_n = 1'h0;
         end else if (!over_volt_n) begin
            if (expired(tick, ocnt, OV_LIM)) begin
               next_over_volt_n = 1'h1;
            end else if (tick) begin
               next_ocnt = ocnt + TCNT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ocnt <= '0;
         over_volt_n <= OV_N_RST;
      end else begin
         ocnt <= next_ocnt;
         over_volt_n <= next_over_volt_n;
      end
   end

   assign reset_n_o = 1'h0;
   assign reset_n_oe = !reset_n;
   assign over_volt_n_o = 1'h0;
   assign over_volt_n_oe = !over_volt_n;
   assign wd_fault_n_o = 1'h0;
   assign wd_fault_n_oe = !wd_fault_n;

   // ticks seen since the last cause, only read by the delay check
   always_ff @(posedge mclk) begin
      if (rst || rst_cause) begin
         clr_ticks <= '0;
      end else if (tick && !freeze && clr_ticks != RST_FULL) begin
         clr_ticks <= clr_ticks + TCNT_W'(1);
      end
   end

   a_reset_on_cause: assert property ( // [R1]
      @(posedge mclk) disable iff (rst) (rst_cause && !freeze) |=> !reset_n_o ##0 reset_n_oe)
      else $error("reset not asserted on cause");

   a_reset_full_delay: assert property ( // [R2] [R11]
      @(posedge mclk) disable iff (rst) $rose(reset_n) |-> clr_ticks == RST_FULL)
      else $error("reset released before full delay");

   a_init_starts: assert property ( // [R4]
      @(posedge mclk) disable iff (rst)
      $rose(wd_fault_n) |-> wcnt == '0 && (wd_state == WD_INIT || wd_state == WD_CLEAR))
      else $error("initial period not started on fault release");

   a_kick_restart: assert property ( // [R5]
      @(posedge mclk) disable iff (rst)
      (wd_state == WD_NORM && kick_fall && reset_n && !freeze) |=> wcnt == '0 && wd_fault_n)
      else $error("kick did not restart normal period");

   a_norm_timeout: assert property ( // [R6] [R3]
      @(posedge mclk) disable iff (rst)
      (wd_state == WD_NORM && tick && wcnt == NORM_LIM && !kick_fall && reset_n && !freeze)
      |=> !wd_fault_n && wd_fault_n_oe)
      else $error("fault not raised at normal timeout");

   a_fault_sticks: assert property ( // [R7]
      @(posedge mclk) disable iff (rst)
      (wd_state == WD_FAULT && reset_n && !kick_edge) |=> !wd_fault_n)
      else $error("fault released without kick transition");

   a_fault_min_pulse: assert property ( // [R8]
      @(posedge mclk) disable iff (rst)
      ($rose(wd_fault_n) && $past(wd_state) == WD_FAULT && !$past(kick_edge))
      |-> $past(hold_cnt) == HOLD_LIM)
      else $error("fault pulse shorter than minimum");

   a_reset_clears_wd: assert property ( // [R9] [R10]
      @(posedge mclk) disable iff (rst)
      (!reset_n && !freeze && wd_state != WD_PWRUP && wd_state != WD_FAULT)
      |=> wd_state == WD_CLEAR ##0 wcnt == '0 ##0 wd_fault_n)
      else $error("watchdog not cleared during reset");

   a_margin_freeze: assert property ( // [R13]
      @(posedge mclk) disable iff (rst)
      freeze |=> $stable(reset_n_oe) && $stable(over_volt_n_oe) && $stable(wd_fault_n_oe))
      else $error("outputs moved during margin hold");

   a_margin_over_mr: assert property ( // [R14]
      @(posedge mclk) disable iff (rst) (freeze && mr_active && reset_n) |=> reset_n)
      else $error("manual reset acted during margin hold");

endmodule : svwd_top

// ===== tb/svwd_host.sv
/*
 Host processor model: kicks the watchdog input at random spacing while enabled.
 Assumes the bench changes en just after a rising mclk edge and wants kicks on falling edges.
*/
`timescale 1ns/1ps
module svwd_host (
   // clock
   input wire logic mclk,
   // control from bench
   input wire logic en,
   // watchdog pin and status
   output logic kick,
   output logic idle
);
   int gap;

   // single edge on demand, only while en is low
   task automatic toggle();
      @(negedge mclk);
      kick = ~kick;
   endtask : toggle

   initial begin
      kick = 1'b0;
      idle = 1'b1;
      forever begin
         @(negedge mclk);
         if (en) begin
            idle = 1'b0;
            // worst spacing stays well under the normal period even for a slow host
            gap = 200 + $urandom_range(400);
            repeat (gap) @(negedge mclk);
            kick = 1'b1;
            repeat (gap) @(negedge mclk);
            kick = 1'b0;
            idle = 1'b1;
         end
      end
   end
endmodule : svwd_host

// ===== tb/svwd_top_test.sv
/*
 Self-checking bench of the supervisor reset and watchdog logic with shortened periods.
 Assumes a 200-cycle timebase tick and the open-drain pins pulled up outside.
*/
`timescale 1ns/1ps
module svwd_top_test;
   import svwd_pkg::*;
   localparam int RD = 5;
   localparam int IW = 20;
   localparam int NW = 10;
   localparam int OD = 3;
   localparam int PU = 4;
   localparam int TK = TICK_CYC;
   logic mclk;
   logic rst;
   logic [NUM_SUP-1:0] uv_flag;
   logic [NUM_SUP-1:0] ov_flag;
   logic mr_drv;
   logic margin_hold_n;
   logic host_en;
   logic host_idle;
   logic loop_on;
   wire logic manual_rst_n;
   wire logic wd_kick_in;
   logic reset_n_oe;
   logic over_volt_n_oe;
   logic wd_fault_n_oe;
   wire logic [2:0] pin_o;
   int n_mismatch = 0;
   int compares = 0;

   // fault pin wired back to manual reset when the loop is closed
   assign manual_rst_n = loop_on ? ~wd_fault_n_oe : mr_drv;

   svwd_top #(.RST_DELAY_T(RD), .INIT_WD_T(IW), .NORM_WD_T(NW), .OV_DELAY_T(OD),
              .PWRUP_T(PU)) dut (
      .mclk(mclk), .rst(rst), .uv_flag(uv_flag), .ov_flag(ov_flag),
      .manual_rst_n(manual_rst_n), .margin_hold_n(margin_hold_n), .wd_kick_in(wd_kick_in),
      .reset_n_o(pin_o[2]), .reset_n_oe(reset_n_oe),
      .over_volt_n_o(pin_o[1]), .over_volt_n_oe(over_volt_n_oe),
      .wd_fault_n_o(pin_o[0]), .wd_fault_n_oe(wd_fault_n_oe));

   svwd_host host (.mclk(mclk), .en(host_en), .kick(wd_kick_in), .idle(host_idle));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // a count outside its window is reported against the lower bound
   task automatic win(input int n, input int lo, input int hi);
      check((n >= lo && n <= hi) ? 32'(lo) : 32'(n), 32'(lo));
   endtask : win

   function automatic logic outv(input logic sel);
      return sel ? wd_fault_n_oe : reset_n_oe;
   endfunction : outv

   task automatic wait_lvl(input logic sel, input logic val, input int lim, output int n);
      n = 0;
      while (outv(sel) !== val && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= lim) check(32'(outv(sel)), 32'(val));
   endtask : wait_lvl

   task automatic results();
      if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   initial begin
      repeat (60000) @(posedge mclk);
      n_mismatch++;
      results();
   end

   initial begin : main
      int n;
      int m;
      rst = 1'b1;
      uv_flag = '0;
      ov_flag = '0;
      mr_drv = 1'b1;
      margin_hold_n = 1'b1;
      host_en = 1'b0;
      loop_on = 1'b0;
      void'($urandom(26));
      repeat (16) @(posedge mclk);
      #1;
      check(32'({reset_n_oe, wd_fault_n_oe}), 32'h3);
      check(32'(pin_o), 32'h0);
      @(negedge mclk);
      rst = 1'b0;
      host_en = 1'b1;
      wait_lvl(1'b1, 1'b0, (PU + 3) * TK, n);
      win(n, (PU - 1) * TK, (PU + 1) * TK + 20);
      wait_lvl(1'b0, 1'b0, (RD + 3) * TK, m);
      win(n + m, RD * TK, (RD + 1) * TK + 40);
      // each supply in turn, with random companions
      for (int i = 0; i < NUM_SUP; i++) begin
         @(negedge mclk);
         uv_flag = (NUM_SUP'(1) << i) | NUM_SUP'($urandom);
         repeat (5) @(posedge mclk);
         #1;
         check(32'(reset_n_oe), 32'h1);
         @(negedge mclk);
         uv_flag = '0;
         wait_lvl(1'b0, 1'b0, (RD + 3) * TK, n);
         win(n, RD * TK, (RD + 1) * TK + 20);
      end
      // short manual pulse is a glitch, a 1us one is not
      @(negedge mclk);
      mr_drv = 1'b0;
      repeat (15) @(negedge mclk);
      mr_drv = 1'b1;
      repeat (40) @(posedge mclk);
      #1;
      check(32'(reset_n_oe), 32'h0);
      @(negedge mclk);
      mr_drv = 1'b0;
      repeat (200) @(negedge mclk);
      check(32'(reset_n_oe), 32'h1);
      mr_drv = 1'b1;
      wait_lvl(1'b0, 1'b0, (RD + 3) * TK, n);
      win(n, RD * TK, (RD + 1) * TK + 40);
      // margin hold freezes outputs against undervoltage, overvoltage and manual reset at once
      @(negedge mclk);
      margin_hold_n = 1'b0;
      repeat (5) @(negedge mclk);
      uv_flag = NUM_SUP'($urandom) | 6'h01;
      ov_flag = NUM_SUP'($urandom) | 6'h20;
      mr_drv = 1'b0;
      repeat (400) @(negedge mclk);
      check(32'({reset_n_oe, over_volt_n_oe, wd_fault_n_oe}), 32'h0);
      margin_hold_n = 1'b1;
      wait_lvl(1'b0, 1'b1, 40, n);
      win(n, 1, 30);
      repeat (30) @(posedge mclk);
      #1;
      check(32'({reset_n_oe, over_volt_n_oe, wd_fault_n_oe}), 32'h6);
      @(negedge mclk);
      uv_flag = '0;
      ov_flag = '0;
      mr_drv = 1'b1;
      wait_lvl(1'b0, 1'b0, (RD + 3) * TK, n);
      win(n, RD * TK, (RD + 1) * TK + 40);
      // live host keeps the watchdog quiet, then stalls
      repeat (8000) @(posedge mclk);
      #1;
      check(32'(wd_fault_n_oe), 32'h0);
      host_en = 1'b0;
      n = 0;
      while (host_idle !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      wait_lvl(1'b1, 1'b1, (NW + 3) * TK, n);
      win(n, (NW - 1) * TK, (NW + 1) * TK + 20);
      repeat (3000) @(posedge mclk);
      #1;
      check(32'(wd_fault_n_oe), 32'h1);
      host.toggle();
      wait_lvl(1'b1, 1'b0, 10, n);
      win(n, 1, 8);
      @(negedge mclk);
      loop_on = 1'b1;
      wait_lvl(1'b1, 1'b1, (IW + NW + 3) * TK, n);
      win(n, (IW + NW - 1) * TK, (IW + NW + 1) * TK + 20);
      wait_lvl(1'b0, 1'b1, 40, m);
      win(m, 15, 30);
      wait_lvl(1'b1, 1'b0, 1100, n);
      win(n + m, 995, 1010);
      repeat (500) @(posedge mclk);
      #1;
      check(32'({reset_n_oe, wd_fault_n_oe}), 32'h2);
      wait_lvl(1'b0, 1'b0, (RD + 3) * TK, m);
      win(m + 500, RD * TK, (RD + 1) * TK + 40);
      @(negedge mclk);
      loop_on = 1'b0;
      results();
   end
endmodule : svwd_top_test
